// File: fsr_host.sv
/*
 Host controller that runs flash instructions and polls their status.
 Assumes software on a plain register port and one flash on the pins.
*/
`timescale 1ns/1ps
module fsr_host
    import fsr_pkg::*;
#(
    parameter int unsigned POLL_MAX = POLL_MAX_DEF
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [7:0] flash_dq_in,
    output logic [11:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_wr_n,
    output logic flash_rd_n,
    output logic [7:0] main_sector_selects,
    output logic [3:0] boot_sector_selects
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_PRE = 4'h1, S_WR = 4'h2, S_FETCH = 4'h3,
        S_POLL = 4'h4, S_RECHK = 4'h5, S_VERIFY = 4'h6, S_RSTW = 4'h7
    } fsr_st_t;
    fsr_st_t st, next_st;
    fsr_op_t op, next_op;
    logic tog, next_tog, done, next_done, fail, next_fail;
    logic first, next_first, prev, next_prev;
    logic [2:0] step, next_step;
    logic [11:0] taddr, next_taddr, sel, next_sel, bad, next_bad;
    logic [7:0] tdata, next_tdata, result, next_result;
    logic [7:0] flags, next_flags;
    logic [15:0] pcnt, next_pcnt, next_rdata;
    logic [19:0] wr_item;
    logic [2:0] last_step;
    logic [7:0] rd;
    logic exp7, pass, sel_bad;
    logic [11:0] flash_sel;
    fsr_cyc_if cyc ();

    fsr_cyc #(.STB(STB_CYC)) u_cyc (
        .mclk(mclk),
        .nrst(nrst),
        .cyc(cyc),
        .flash_dq_in(flash_dq_in),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_wr_n(flash_wr_n),
        .flash_rd_n(flash_rd_n),
        .flash_sel(flash_sel)
    );
    assign main_sector_selects = flash_sel[7:0];
    assign boot_sector_selects = flash_sel[11:8];

    function automatic logic [19:0] fsr_item(fsr_op_t o, logic [2:0] i,
        logic [11:0] a, logic [7:0] d);
        logic [7:0] code;
        code = (o == OP_PROG) ? CODE_PROG :
               (o == OP_SECT || o == OP_BULK) ? CODE_ERASE : CODE_IDENT;
        case (i)
            3'd0: fsr_item = (o == OP_RESET) ? {UNLOCK1_A, CODE_RESET}
                                             : {UNLOCK1_A, UNLOCK1_D};
            3'd1: fsr_item = {UNLOCK2_A, UNLOCK2_D};
            3'd2: fsr_item = {UNLOCK1_A, code};
            3'd3: fsr_item = (o == OP_PROG) ? {a, d} : {UNLOCK1_A, UNLOCK1_D};
            3'd4: fsr_item = {UNLOCK2_A, UNLOCK2_D};
            default: fsr_item = (o == OP_SECT) ? {a, CODE_SECT}
                                               : {UNLOCK1_A, CODE_BULK};
        endcase
    endfunction

    // Last write index of each instruction
    always_comb
    begin
        case (op)
            OP_RESET: last_step = 3'd0;
            OP_IDENT, OP_PROT: last_step = 3'd2;
            OP_PROG: last_step = 3'd3;
            default: last_step = 3'd5;
        endcase
    end

    // Cycle request towards the pin engine
    always_comb
    begin
        wr_item = fsr_item(op, step, taddr, tdata);
        cyc.req = (st != S_IDLE);
        cyc.we = (st == S_WR) || (st == S_RSTW);
        cyc.sel = sel;
        cyc.wdata = (st == S_RSTW) ? CODE_RESET : wr_item[7:0];
        case (st)
            S_WR: cyc.addr = wr_item[19:8];
            S_RSTW: cyc.addr = UNLOCK1_A;
            S_FETCH: cyc.addr = (op == OP_IDENT) ? IDENT_A :
                (op == OP_PROT) ? {taddr[11:2], PROT_LO} : taddr;
            default: cyc.addr = taddr;
        endcase
    end

    assign rd = cyc.rdata;
    assign exp7 = (op == OP_PROG) ? tdata[DP_BIT] : 1'b1;
    assign pass = tog ? (!first && rd[TG_BIT] == prev) : (rd[DP_BIT] == exp7);
    assign sel_bad = |(sel & bad);

    // Sequencer and software registers
    always_comb
    begin
        next_st = st;
        next_op = op;
        next_tog = tog;
        next_done = done;
        next_fail = fail;
        next_first = first;
        next_prev = prev;
        next_step = step;
        next_taddr = taddr;
        next_sel = sel;
        next_tdata = tdata;
        next_result = result;
        next_flags = flags;
        next_pcnt = pcnt;
        next_bad = bad;
        next_rdata = '0;
        if (reg_wr && reg_addr == REG_BAD)
            next_bad = bad & ~reg_wdata[11:0];
        case (st)
            S_IDLE:
                if (reg_wr)
                begin
                    case (reg_addr)
                        REG_ADDR: next_taddr = reg_wdata[11:0];
                        REG_DATA: next_tdata = reg_wdata[7:0];
                        REG_SEL: next_sel = reg_wdata[11:0];
                        REG_CMD:
                        begin
                            next_op = fsr_op_t'(reg_wdata[2:0]);
                            next_tog = reg_wdata[CMD_TOG_BIT];
                            next_done = 1'b0;
                            next_fail = 1'b0;
                            next_step = '0;
                            next_first = 1'b1;
                            next_pcnt = '0;
                            next_st = S_WR;
                            if (reg_wdata[2:0] == 3'(OP_READ))
                                next_st = S_FETCH;
                            else if (reg_wdata[2:0] == 3'(OP_PROG))
                                next_st = S_PRE;
                            if (sel_bad && (reg_wdata[2:0] == 3'(OP_PROG)
                                || reg_wdata[2:0] == 3'(OP_SECT)
                                || reg_wdata[2:0] == 3'(OP_BULK)))
                            begin
                                next_fail = 1'b1;
                                next_done = 1'b1;
                                next_st = S_IDLE;
                            end
                        end
                        default: ;
                    endcase
                end
            S_PRE:
                if (cyc.ack)
                begin
                    if ((rd & tdata) != tdata)
                    begin
                        next_fail = 1'b1;
                        next_done = 1'b1;
                        next_st = S_IDLE;
                    end
                    else
                        next_st = S_WR;
                end
            S_WR:
                if (cyc.ack)
                begin
                    next_step = step + 3'd1;
                    if (step == last_step)
                        case (op)
                            OP_RESET:
                            begin
                                next_done = 1'b1;
                                next_st = S_IDLE;
                            end
                            OP_IDENT, OP_PROT: next_st = S_FETCH;
                            default: next_st = S_POLL;
                        endcase
                end
            S_FETCH:
                if (cyc.ack)
                begin
                    next_result = rd;
                    next_st = (op == OP_READ) ? S_IDLE : S_RSTW;
                    next_done = (op == OP_READ);
                end
            S_POLL, S_RECHK:
                if (cyc.ack)
                begin
                    next_flags = rd & FLAG_MASK;
                    next_prev = rd[TG_BIT];
                    next_first = 1'b0;
                    next_pcnt = pcnt + 16'd1;
                    if (pass)
                    begin
                        next_st = (op == OP_PROG) ? S_VERIFY : S_IDLE;
                        next_done = (op != OP_PROG);
                    end
                    else if (st == S_POLL && rd[ER_BIT])
                        next_st = S_RECHK;
                    else if (st == S_RECHK || pcnt == 16'(POLL_MAX - 1))
                    begin
                        next_fail = 1'b1;
                        next_bad = next_bad | sel;
                        next_st = S_RSTW;
                    end
                end
            S_VERIFY:
                if (cyc.ack)
                begin
                    next_result = rd;
                    if (rd != tdata)
                    begin
                        next_fail = 1'b1;
                        next_bad = next_bad | sel;
                    end
                    next_done = 1'b1;
                    next_st = S_IDLE;
                end
            S_RSTW:
                if (cyc.ack)
                begin
                    next_done = 1'b1;
                    next_st = S_IDLE;
                end
            default: next_st = S_IDLE;
        endcase
        if (reg_rd)
            case (reg_addr)
                REG_CMD: next_rdata = {13'h0, fail, done, st != S_IDLE};
                REG_ADDR: next_rdata = {4'h0, taddr};
                REG_DATA: next_rdata = {8'h0, tdata};
                REG_SEL: next_rdata = {4'h0, sel};
                REG_RESULT: next_rdata = {8'h0, result};
                REG_FLAGS: next_rdata = {8'h0, flags};
                REG_BAD: next_rdata = {4'h0, bad};
                default: next_rdata = '0;
            endcase
    end

    // State registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= S_IDLE;
            op <= OP_READ;
            tog <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            first <= 1'b1;
            prev <= 1'b0;
            step <= '0;
            taddr <= '0;
            sel <= '0;
            tdata <= '0;
            result <= '0;
            flags <= '0;
            pcnt <= '0;
            bad <= '0;
            reg_rdata <= '0;
        end
        else
        begin
            st <= next_st;
            op <= next_op;
            tog <= next_tog;
            done <= next_done;
            fail <= next_fail;
            first <= next_first;
            prev <= next_prev;
            step <= next_step;
            taddr <= next_taddr;
            sel <= next_sel;
            tdata <= next_tdata;
            result <= next_result;
            flags <= next_flags;
            pcnt <= next_pcnt;
            bad <= next_bad;
            reg_rdata <= next_rdata;
        end
    end

    sequence s_first_write;
        st == S_WR && step == 3'd0 && op != OP_RESET;
    endsequence
    a_unlock_first: assert property (@(posedge mclk) disable iff (!nrst)
        s_first_write |-> cyc.addr == UNLOCK1_A && cyc.wdata == UNLOCK1_D)
        else $error("instruction does not open with unlock");
    a_prot_addr: assert property (@(posedge mclk) disable iff (!nrst)
        st == S_FETCH && op == OP_PROT |-> cyc.addr[1:0] == PROT_LO)
        else $error("protection read address wrong");
    a_flag_mask: assert property (@(posedge mclk) disable iff (!nrst)
        (flags & ~FLAG_MASK) == 8'h00)
        else $error("undefined status bits kept");
    a_fail_marks_bad: assert property (
        @(posedge mclk) disable iff (!nrst)
        st == S_RECHK && cyc.ack && !pass |=> (bad & sel) == sel)
        else $error("failed sector not marked");
    a_reset_after_id: assert property (
        @(posedge mclk) disable iff (!nrst)
        st == S_FETCH && cyc.ack && op != OP_READ |=> st == S_RSTW)
        else $error("no reset after special read");
endmodule // fsr_host

// File: fsr_pkg.sv
/*
 Shared constants and types of the flash status host controller.
 Assumes a 25 MHz mclk and an 8-bit parallel flash bus with 12 address bits.
*/
package fsr_pkg;
    // Clock and bus-cycle timing
    localparam int unsigned CLK_NS = 40;
    localparam int unsigned STB_NS = 160;
    localparam int unsigned STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned POLL_MAX_DEF = 65535;
    // Software register offsets
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_SEL = 3'h3;
    localparam logic [2:0] REG_RESULT = 3'h4;
    localparam logic [2:0] REG_FLAGS = 3'h5;
    localparam logic [2:0] REG_BAD = 3'h6;
    // Command register fields
    localparam int unsigned CMD_TOG_BIT = 3;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_FAIL_BIT = 2;
    // Flash instruction codes and addresses
    localparam logic [11:0] UNLOCK1_A = 12'h555;
    localparam logic [11:0] UNLOCK2_A = 12'haaa;
    localparam logic [7:0] UNLOCK1_D = 8'haa;
    localparam logic [7:0] UNLOCK2_D = 8'h55;
    localparam logic [7:0] CODE_IDENT = 8'h90;
    localparam logic [7:0] CODE_PROG = 8'ha0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_SECT = 8'h30;
    localparam logic [7:0] CODE_BULK = 8'h10;
    localparam logic [7:0] CODE_RESET = 8'hf0;
    localparam logic [11:0] IDENT_A = 12'h001;
    localparam logic [1:0] PROT_LO = 2'b10;
    // Status byte fields
    localparam int unsigned DP_BIT = 7;
    localparam int unsigned TG_BIT = 6;
    localparam int unsigned ER_BIT = 5;
    localparam int unsigned ET_BIT = 3;
    localparam logic [7:0] FLAG_MASK = 8'h80 | 8'h40 | 8'h20 | 8'h08;
    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_IDENT = 3'h1, OP_PROT = 3'h2, OP_PROG = 3'h3,
        OP_SECT = 3'h4, OP_BULK = 3'h5, OP_RESET = 3'h6
    } fsr_op_t;
endpackage

// File: fsr_cyc_if.sv
/*
 Bus-cycle request channel between the sequencer and the pin engine.
 Assumes both ends run on mclk; req is a level, ack a one-cycle pulse.
*/
`timescale 1ns/1ps
interface fsr_cyc_if;
    logic req;
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [11:0] sel;
    logic ack;
    logic [7:0] rdata;
    modport seq (output req, we, addr, wdata, sel, input ack, rdata);
    modport eng (input req, we, addr, wdata, sel, output ack, rdata);
endinterface

// File: fsr_cyc.sv
/*
 Pin engine: runs one flash write or read cycle per request.
 Assumes flash_dq_in is asynchronous to mclk; it is synchronised here.
*/
`timescale 1ns/1ps
module fsr_cyc
    import fsr_pkg::*;
#(
    parameter int unsigned STB = STB_CYC
)
(
    input wire logic mclk,
    input wire logic nrst,
    fsr_cyc_if.eng cyc,
    input wire logic [7:0] flash_dq_in,
    output logic [11:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_wr_n,
    output logic flash_rd_n,
    output logic [11:0] flash_sel
);
    typedef enum logic [1:0] {
        E_IDLE = 2'b00, E_SET = 2'b01, E_STB = 2'b10, E_HLD = 2'b11
    } fsr_eng_t;
    fsr_eng_t st, next_st;
    logic [2:0] cnt, next_cnt;
    logic we, next_we;
    logic [7:0] sync1, sync2, rdat, next_rdat;
    logic [11:0] next_addr, next_sel;
    logic [7:0] next_dout;
    logic next_oe, next_wr_n, next_rd_n;

    assign cyc.ack = (st == E_HLD);
    assign cyc.rdata = rdat;

    // Next cycle phase and pin values
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_we = we;
        next_rdat = rdat;
        next_addr = flash_addr;
        next_sel = flash_sel;
        next_dout = flash_dq_out;
        next_oe = flash_dq_oe;
        next_wr_n = flash_wr_n;
        next_rd_n = flash_rd_n;
        case (st)
            E_IDLE:
                if (cyc.req)
                begin
                    next_we = cyc.we;
                    next_addr = cyc.addr;
                    next_dout = cyc.wdata;
                    next_sel = cyc.sel;
                    next_oe = cyc.we;
                    next_st = E_SET;
                end
            E_SET:
            begin
                next_wr_n = !we;
                next_rd_n = we;
                next_cnt = '0;
                next_st = E_STB;
            end
            E_STB:
            begin
                next_cnt = cnt + 3'd1;
                if (cnt == 3'(STB - 1))
                begin
                    next_rdat = sync2;
                    next_wr_n = 1'b1;
                    next_rd_n = 1'b1;
                    next_st = E_HLD;
                end
            end
            default:
            begin
                next_oe = 1'b0;
                next_sel = '0;
                next_st = E_IDLE;
            end
        endcase
    end

    // Registers and the two-stage input synchroniser
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= E_IDLE;
            cnt <= '0;
            we <= 1'b0;
            sync1 <= '0;
            sync2 <= '0;
            rdat <= '0;
            flash_addr <= '0;
            flash_sel <= '0;
            flash_dq_out <= '0;
            flash_dq_oe <= 1'b0;
            flash_wr_n <= 1'b1;
            flash_rd_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            we <= next_we;
            sync1 <= flash_dq_in;
            sync2 <= sync1;
            rdat <= next_rdat;
            flash_addr <= next_addr;
            flash_sel <= next_sel;
            flash_dq_out <= next_dout;
            flash_dq_oe <= next_oe;
            flash_wr_n <= next_wr_n;
            flash_rd_n <= next_rd_n;
        end
    end

    a_wr_pulse_len: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(flash_wr_n) |-> !flash_wr_n [*4] ##1 flash_wr_n)
        else $error("write strobe width wrong");
    a_strobe_excl: assert property (@(posedge mclk) disable iff (!nrst)
        !(!flash_wr_n && !flash_rd_n))
        else $error("both strobes low");
    a_oe_on_write: assert property (@(posedge mclk) disable iff (!nrst)
        !flash_wr_n |-> flash_dq_oe && !$past(flash_wr_n) || $fell(flash_wr_n)
        ##0 flash_dq_oe)
        else $error("data not driven during write");
    a_sel_on_cycle: assert property (@(posedge mclk) disable iff (!nrst)
        (!flash_wr_n || !flash_rd_n) |-> flash_sel == $past(flash_sel))
        else $error("sector select moved during strobe");
endmodule // fsr_cyc

// File: fsr_flash_model.sv
/*
 Behavioural flash device facing the host controller pins.
 Assumes low-active strobes, high-active selects, one byte per cycle.
*/
`timescale 1ns/1ps
module fsr_flash_model
    import fsr_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary identifier value
    parameter logic [11:0] PROT = 12'h002,
    parameter int BUSY = 3
)
(
    input wire logic [11:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_wr_n,
    input wire logic flash_rd_n,
    input wire logic [7:0] main_sector_selects,
    input wire logic [3:0] boot_sector_selects,
    input wire logic fault,
    output logic [7:0] flash_dq_in
);
    logic [7:0] mem [0:4095];
    logic [7:0] dout, pdat;
    logic [11:0] pa, sel;
    logic tog, err, ers, idm, et, pr;
    int stp, busy, wcnt;
    assign sel = {boot_sector_selects, main_sector_selects};
    // Released bus shows the inverse of the last byte
    assign flash_dq_in = flash_rd_n ? ~dout : dout;
    // Erased array, read mode
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
        {tog, err, ers, idm, pr, et, dout, pdat, pa} = 34'h1_0000_0000;
        {stp, busy, wcnt} = '0;
    end
    always @(posedge flash_wr_n)
    if (|sel)
    begin
        wcnt++;
        if (flash_dq_out == CODE_RESET)
            {stp, busy, idm, err} = '0;
        else if (stp == 0)
            stp = (flash_dq_out == UNLOCK1_D && flash_addr == UNLOCK1_A);
        else if (stp == 1)
            stp = (flash_dq_out == UNLOCK2_D
                && flash_addr == UNLOCK2_A) ? 2 : 0;
        else if (stp == 2)
        begin
            idm = flash_dq_out == CODE_IDENT;
            stp = flash_dq_out == CODE_PROG ? 3 :
                  flash_dq_out == CODE_ERASE ? 4 : 0;
        end
        else if (stp == 4 || stp == 5)
            stp = (flash_dq_out == (stp == 4 ? UNLOCK1_D : UNLOCK2_D))
                ? stp + 1 : 0;
        else
        begin
            pr = |(sel & PROT);
            ers = stp == 6;
            et = !ers;
            pa = flash_addr;
            pdat = flash_dq_out;
            // Fault stands for an internal program attempt timing out
            err = !ers && (fault || |(flash_dq_out & ~mem[flash_addr]));
            busy = (ers || !pr) ? BUSY : 0;
            stp = 0;
        end
    end
    always @(negedge flash_rd_n)
    if (|sel)
    begin
        if (busy > 0)
        begin
            tog = ~tog;
            dout = pr ? 8'h00
                : {ers ? 1'b0 : ~pdat[7], tog, err, 1'b0, et, 3'h0};
        end
        else if (idm)
            dout = flash_addr[1:0] == PROT_LO
                ? {7'h0, |(sel & PROT)} : ID_CODE;
        else
            dout = mem[flash_addr];
    end
    // operation ends after BUSY status reads
    always @(posedge flash_rd_n)
    if (busy > 0)
    begin
        busy--;
        et = 1'b1;
        if (busy == 0 && !pr && !err)
        begin
            if (ers)
                foreach (mem[i]) mem[i] = 8'hff;
            else
                mem[pa] = mem[pa] & pdat;
        end
    end
endmodule // fsr_flash_model

// File: fsr_host_tb.sv
/*
 Self-checking bench of the flash status host controller.
 Assumes the behavioural flash model on the pins and 25 MHz mclk.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) \
    begin \
        comparisons++; \
        if ((s) !== (e)) \
        begin \
            fail_count++; \
            $display("FAIL %s expected %h seen %h", n, e, s); \
        end \
    end
module fsr_host_tb
    import fsr_pkg::*;
;
    localparam logic [7:0] ID = 8'h5a;
    localparam logic [11:0] PROT = 12'h002;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rv = 1'b0;
    logic fault = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata, last;
    logic [7:0] dq_in, dq_out, msel, d0;
    logic [11:0] fa, a0;
    logic [3:0] bsel;
    logic oe, wr_n, rd_n;
    logic [31:0] q[$];
    int fail_count = 0;
    int comparisons = 0;
    int seed = 96;
    int cyc = 0;
    int w0;
    initial forever #20 mclk = ~mclk;
    fsr_host #(.POLL_MAX(20)) i_dut (.mclk(mclk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_dq_in(dq_in),
        .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(oe),
        .flash_wr_n(wr_n), .flash_rd_n(rd_n),
        .main_sector_selects(msel), .boot_sector_selects(bsel));
    fsr_flash_model #(.ID_CODE(ID), .PROT(PROT)) i_flash (.flash_addr(fa),
        .flash_dq_out(dq_out), .flash_wr_n(wr_n), .flash_rd_n(rd_n),
        .main_sector_selects(msel), .boot_sector_selects(bsel),
        .flash_dq_in(dq_in), .fault(fault));
    // Register write, one strobe cycle
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Register read, noting mask and expected value
    task automatic rd(input logic [2:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q.push_back({m, e});
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    // Start an operation and poll busy under a bound
    task automatic run(input logic [2:0] o, input logic [11:0] a,
                       input logic [7:0] d, input logic [11:0] s,
                       input logic t);
        wr(REG_ADDR, {4'h0, a});
        wr(REG_DATA, {8'h0, d});
        wr(REG_SEL, {4'h0, s});
        wr(REG_CMD, {12'h0, t, o});
        for (int n = 0; n < 300; n++)
        begin
            rd(REG_CMD, 16'h0, 16'h0);
            repeat (2) @(posedge mclk);
            if (last[ST_BUSY_BIT] === 1'b0) break;
        end
        `CHK("busy", 1'b0, last[ST_BUSY_BIT])
    endtask
    // Status and result of the finished operation
    task automatic chk(input logic [1:0] st, input logic [15:0] res);
        rd(REG_CMD, 16'h0006, {13'h0, st, 1'b0});
        rd(REG_RESULT, 16'h00ff, res);
    endtask
    // Verdict and end of run
    task conclude;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Oldest note against each read answer
    always @(posedge mclk)
    begin
        rv <= reg_rd;
        if (rv)
        begin
            last = reg_rdata;
            if (q[0][31:16] != 16'h0)
                `CHK("reg_rdata", q[0][15:0], reg_rdata & q[0][31:16])
            void'(q.pop_front());
        end
    end
    // Hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fail_count++;
            conclude;
        end
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rd(3'h7, 16'hffff, 16'h0);
        w0 = i_flash.wcnt;
        run(OP_IDENT, 12'h0, 8'h0, 12'h001, 1'b0);
        chk(2'b01, {8'h0, ID});
        `CHK("writes", 4, i_flash.wcnt - w0)
        for (int i = 0; i < 2; i++)
        begin
            run(OP_PROT, 12'h0, 8'h0, i ? PROT : 12'h001, 1'b0);
            chk(2'b01, 16'(i));
        end
        for (int k = 0; k < 4; k++)
        begin
            a0 = {2'(k), 10'($random(seed))};
            d0 = 8'($random(seed)) & 8'h7f;
            run(OP_PROG, a0, d0, 12'h001, k[0]);
            chk(2'b01, {8'h0, d0});
        end
        run(OP_PROG, a0, 8'hff, 12'h001, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0006);
        rd(REG_BAD, 16'h0fff, 16'h0000);
        fault <= 1'b1;
        run(OP_PROG, a0, d0, 12'h001, 1'b0);
        fault <= 1'b0;
        rd(REG_CMD, 16'h0006, 16'h0006);
        rd(REG_FLAGS, 16'h0020, 16'h0020);
        rd(REG_BAD, 16'h0fff, 16'h0001);
        run(OP_PROG, a0, 8'h00, 12'h001, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0006);
        wr(REG_BAD, 16'h0001);
        run(OP_SECT, a0, 8'h0, 12'h001, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0002);
        rd(REG_FLAGS, 16'h00ff, {8'h0, FLAG_MASK});
        run(OP_READ, a0, 8'h0, 12'h001, 1'b0);
        chk(2'b01, 16'h00ff);
        run(OP_PROG, a0, 8'h00, PROT, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0006);
        rd(REG_BAD, 16'h0fff, {4'h0, PROT});
        run(OP_READ, a0, 8'h0, PROT, 1'b0);
        chk(2'b01, 16'h00ff);
        wr(REG_BAD, {4'h0, PROT});
        run(OP_SECT, a0, 8'h0, PROT, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0002);
        run(OP_BULK, a0, 8'h0, 12'h001, 1'b1);
        rd(REG_CMD, 16'h0006, 16'h0002);
        w0 = i_flash.wcnt;
        run(OP_RESET, 12'h0, 8'h0, 12'h001, 1'b0);
        rd(REG_CMD, 16'h0006, 16'h0002);
        `CHK("writes", 1, i_flash.wcnt - w0)
        repeat (3) @(posedge mclk);
        conclude;
    end
endmodule // fsr_host_tb
